/* rtl/rx_addr_pkg.sv */
// constants, types and helpers for the receive cell port address block
package rx_addr_pkg;

  localparam int N_CHAN = 4;
  localparam int CH_W = 2;
  localparam int ADDR_W = 5;
  localparam int REG_W = 8;
  localparam int HADDR_W = 32;
  localparam int HDATA_W = 32;

  // register indices; the byte address is four times the index
  localparam logic [11:0] CTRL_IDX = 12'h0503;
  localparam logic [11:0] ADDR_VAL_IDX = 12'h0513;
  localparam logic [11:0] ADDR_PTR_IDX = 12'h0517;
  localparam logic [11:0] STATUS_IDX = 12'h0520;
  localparam logic [17:0] IDX_UPPER_ZERO = 18'h0_0000;
  localparam logic [1:0] WORD_LANE = 2'h0;

  // control register layout and reset value
  localparam int MPHY_BIT = 6;
  localparam logic [REG_W-1:0] CTRL_RST = 8'hCC;

  // address and pointer fields
  localparam logic [ADDR_W-1:0] RESERVED_ADDR = 5'h1F;
  localparam logic [ADDR_W-1:0] ADDR_RST = 5'h1F;
  localparam logic [ADDR_W-1:0] PTR_RST = 5'h00;
  localparam logic [ADDR_W-1:0] PTR_LIMIT = 5'h04;

  // status register layout
  localparam int ST_CLAV_OE = 0;
  localparam int ST_CLAV = 1;
  localparam int ST_HIT_CH = 2;
  localparam int ST_SEL = 4;
  localparam int ST_SEL_CH = 5;
  localparam int ST_MPHY = 7;

  // link pin bundle: clock, enable, five address bits
  localparam int LINK_W = 7;
  localparam int LK_CLK = 0;
  localparam int LK_EN_N = 1;
  localparam int LK_ADDR = 2;

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef logic [N_CHAN-1:0][ADDR_W-1:0] chan_addr_t;

  typedef enum logic {
    LINK_IDLE,
    LINK_SELECTED
  } link_state_t;

  // the reserved all-ones value never names a channel
  function automatic logic addr_hit(input logic [ADDR_W-1:0] bus_addr,
                                    input logic [ADDR_W-1:0] stored);
    addr_hit = (bus_addr == stored) && (stored != RESERVED_ADDR);
  endfunction

  function automatic logic reg_hit(input logic [HADDR_W-1:0] addr,
                                   input logic [11:0] idx);
    reg_hit = (addr == {IDX_UPPER_ZERO, idx, WORD_LANE});
  endfunction

endpackage

/* rtl/rx_addr_match.sv */
// compares the sampled bus address with the four stored receive addresses
`timescale 1ns/1ns
module rx_addr_match
  import rx_addr_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // sample strobe and sampled bus address
  input wire logic i_sample,
  input wire logic [ADDR_W-1:0] i_bus_addr,
  // stored receive addresses, one per channel
  input wire chan_addr_t i_chan_addr,
  // registered result
  output logic o_hit,
  output logic [CH_W-1:0] o_chan
);

  logic [N_CHAN-1:0] hit_vec;
  logic any_hit;
  logic [CH_W-1:0] hit_chan;

  // only receive addresses take part; transmit ones live elsewhere
  always_comb begin
    for (int c = 0; c < N_CHAN; c++) begin
      hit_vec[c] = addr_hit(i_bus_addr, i_chan_addr[c]);
    end
  end

  assign any_hit = |hit_vec;

  // lowest channel wins should software break the uniqueness promise
  always_comb begin
    hit_chan = '0;
    for (int c = N_CHAN - 1; c >= 0; c--) begin
      if (hit_vec[c]) begin
        hit_chan = CH_W'(c);
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_hit <= 1'b0;
      o_chan <= '0;
    end else if (i_sample) begin
      o_hit <= any_hit;
      o_chan <= hit_chan;
    end
  end

endmodule

/* rtl/rx_channel_address_assign.sv */
// receive cell port: per-channel bus address assignment and polling answer
//
// What this block does
// - channel-select register points the assignment pointer at channel 0..3.
// - address write stores into the pointed channel only; others unchanged.
// - receive address writes never touch any transmit address.
// - multi-PHY enabled means polling answers once a channel's receive address is written; reset leaves all four reserved.
// - shared outputs are driven only while this device is addressed.
// - one five-bit bus addresses all blocks; each decodes its own.
// - receive decoder compares only against receive addresses.
// - control register bit 6 enables multi-PHY operation.
// - each receive channel is identified by a five-bit address.
// - sample address each link clock rise; no match keeps clav released.
// - on match drive clav high if a full cell waits, else low.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ns
module rx_channel_address_assign
  import rx_addr_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [HADDR_W-1:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [HDATA_W-1:0] i_hwdata,
  input wire logic i_hready,
  output logic [HDATA_W-1:0] o_hrdata,
  output logic o_hreadyout,
  output logic [1:0] o_hresp,
  // receive cell bus pins from the layer processor
  input wire logic i_rx_cell_bus_clock,
  input wire logic i_rx_read_enable_n,
  input wire logic [ADDR_W-1:0] i_rx_phy_address_in,
  // receive buffer fill status, one bit per channel
  input wire logic [N_CHAN-1:0] i_rx_cell_ready,
  // cell-available pin; multi-PHY releases it when not addressed, single-PHY always drives it
  output logic o_rx_cell_available,
  output logic o_rx_cell_available_oe,
  // selection towards the cell transfer logic
  output logic o_rx_shared_drive_en,
  output logic o_rx_channel_selected,
  output logic [CH_W-1:0] o_rx_selected_channel,
  output logic o_multi_phy_enable
);

  // register state
  logic [REG_W-1:0] ctrl_reg;
  logic [REG_W-1:0] ctrl_next;
  logic [ADDR_W-1:0] rx_channel_select_reg;
  logic [ADDR_W-1:0] rx_channel_select_next;
  chan_addr_t rx_addr_reg;
  chan_addr_t rx_addr_next;

  // bus data phase state
  logic wr_pend_reg;
  logic [HADDR_W-1:0] wr_addr_reg;
  logic [HDATA_W-1:0] hrdata_reg;
  logic [HDATA_W-1:0] hrdata_next;

  // link synchroniser and filtered levels
  logic [LINK_W-1:0] sync1_reg;
  logic [LINK_W-1:0] sync2_reg;
  logic [LINK_W-1:0] sync3_reg;
  logic [LINK_W-1:0] link_reg;
  logic [LINK_W-1:0] link_next;
  logic link_clk_prev_reg;
  logic link_rise_d_reg;

  // link side state
  link_state_t link_state_reg;
  link_state_t link_state_next;
  logic [CH_W-1:0] sel_chan_reg;
  logic [CH_W-1:0] sel_chan_next;

  // matcher results
  logic hit;
  logic [CH_W-1:0] hit_chan;

  // bus decode
  wire addr_phase = i_hsel & i_hready & i_htrans[1];
  wire wr_req = addr_phase & i_hwrite;
  wire rd_req = addr_phase & ~i_hwrite;
  wire wr_ctrl = wr_pend_reg & reg_hit(wr_addr_reg, CTRL_IDX);
  wire wr_val = wr_pend_reg & reg_hit(wr_addr_reg, ADDR_VAL_IDX);
  wire wr_ptr = wr_pend_reg & reg_hit(wr_addr_reg, ADDR_PTR_IDX);
  wire [REG_W-1:0] wdata_byte = i_hwdata[REG_W-1:0];
  wire [ADDR_W-1:0] wdata_field = i_hwdata[ADDR_W-1:0];

  // pointer values above the last channel select nothing
  function automatic logic ptr_ok(input logic [ADDR_W-1:0] ptr);
    ptr_ok = (ptr < PTR_LIMIT);
  endfunction

  function automatic logic [CH_W-1:0] ptr_chan_of(
      input logic [ADDR_W-1:0] ptr);
    ptr_chan_of = ptr[CH_W-1:0];
  endfunction

  wire ptr_valid = ptr_ok(rx_channel_select_reg);
  wire [CH_W-1:0] ptr_chan = ptr_chan_of(rx_channel_select_reg);
  wire ptr_next_valid = ptr_ok(rx_channel_select_next);
  wire [CH_W-1:0] ptr_next_chan = ptr_chan_of(rx_channel_select_next);

  wire multi_phy = ctrl_reg[MPHY_BIT];

  // link edge and sampled bus
  wire link_clk = link_reg[LK_CLK];
  wire link_rise = link_clk & ~link_clk_prev_reg;
  wire link_en_n = link_reg[LK_EN_N];
  wire [ADDR_W-1:0] link_addr = link_reg[LK_ADDR +: ADDR_W];

  // register writes land in the data phase
  always_comb begin
    ctrl_next = ctrl_reg;
    rx_channel_select_next = rx_channel_select_reg;
    rx_addr_next = rx_addr_reg;
    if (wr_ctrl) begin
      ctrl_next = wdata_byte;
    end
    if (wr_ptr) begin
      rx_channel_select_next = wdata_field;
    end
    // only the pointed channel's receive address changes
    if (wr_val && ptr_valid) begin
      rx_addr_next[ptr_chan] = wdata_field;
    end
  end

  // read mux looks at next values so a read right after a write sees it
  always_comb begin
    hrdata_next = '0;
    if (rd_req) begin
      if (reg_hit(i_haddr, CTRL_IDX)) begin
        hrdata_next[REG_W-1:0] = ctrl_next;
      end else if (reg_hit(i_haddr, ADDR_PTR_IDX)) begin
        hrdata_next[ADDR_W-1:0] = rx_channel_select_next;
      end else if (reg_hit(i_haddr, ADDR_VAL_IDX)) begin
        if (ptr_next_valid) begin
          hrdata_next[ADDR_W-1:0] = rx_addr_next[ptr_next_chan];
        end
      end else if (reg_hit(i_haddr, STATUS_IDX)) begin
        hrdata_next[ST_CLAV_OE] = o_rx_cell_available_oe;
        hrdata_next[ST_CLAV] = o_rx_cell_available;
        hrdata_next[ST_HIT_CH +: CH_W] = hit_chan;
        hrdata_next[ST_SEL] = o_rx_channel_selected;
        hrdata_next[ST_SEL_CH +: CH_W] = sel_chan_reg;
        hrdata_next[ST_MPHY] = multi_phy;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_reg <= CTRL_RST;
      rx_channel_select_reg <= PTR_RST;
      rx_addr_reg <= {N_CHAN{ADDR_RST}};
    end else begin
      ctrl_reg <= ctrl_next;
      rx_channel_select_reg <= rx_channel_select_next;
      rx_addr_reg <= rx_addr_next;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata_reg <= '0;
    end else begin
      if (i_hready) begin
        wr_pend_reg <= wr_req;
        wr_addr_reg <= i_haddr;
        hrdata_reg <= hrdata_next;
      end
    end
  end

  // never stretched, never an error; unmapped reads give zero
  assign o_hrdata = hrdata_reg;
  assign o_hreadyout = 1'b1;
  assign o_hresp = HRESP_OKAY;

  // three-stage synchroniser; a bit is accepted once stages two and three
  // agree, which filters a one-sample glitch at the cost of a cycle
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= {i_rx_phy_address_in, i_rx_read_enable_n,
                    i_rx_cell_bus_clock};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_comb begin
    for (int b = 0; b < LINK_W; b++) begin
      link_next[b] = (sync2_reg[b] == sync3_reg[b]) ? sync3_reg[b]
                                                     : link_reg[b];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      link_reg <= '0;
      link_clk_prev_reg <= 1'b0;
      link_rise_d_reg <= 1'b0;
    end else begin
      link_reg <= link_next;
      link_clk_prev_reg <= link_clk;
      link_rise_d_reg <= link_rise;
    end
  end

  // address compared with all four receive addresses at each link rise
  rx_addr_match u_match (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_sample(link_rise),
    .i_bus_addr(link_addr),
    .i_chan_addr(rx_addr_reg),
    .o_hit(hit),
    .o_chan(hit_chan)
  );

  // the matcher answers one cycle after the rise, so selection acts then;
  // with enable negated a match selects and a miss hands the bus on
  wire select_rise = link_rise_d_reg & link_en_n & multi_phy;

  always_comb begin
    link_state_next = link_state_reg;
    sel_chan_next = sel_chan_reg;
    unique case (link_state_reg)
      LINK_IDLE: begin
        if (select_rise && hit) begin
          link_state_next = LINK_SELECTED;
          sel_chan_next = hit_chan;
        end
      end
      LINK_SELECTED: begin
        if (select_rise && hit) begin
          sel_chan_next = hit_chan;
        end else if (select_rise || !multi_phy) begin
          link_state_next = LINK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      link_state_reg <= LINK_IDLE;
      sel_chan_reg <= '0;
    end else begin
      link_state_reg <= link_state_next;
      sel_chan_reg <= sel_chan_next;
    end
  end

  // hit was taken one cycle after the rise with the address of that
  // rise, so polling answers well inside one link clock period
  wire clav_drive = multi_phy ? hit : 1'b1;
  wire clav_level = multi_phy ? i_rx_cell_ready[hit_chan]
                              : |i_rx_cell_ready;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rx_cell_available <= 1'b0;
      o_rx_cell_available_oe <= 1'b0;
    end else begin
      o_rx_cell_available_oe <= clav_drive;
      o_rx_cell_available <= clav_drive & clav_level;
    end
  end

  // data and start-of-cell outputs belong to the cell transfer logic
  wire selected = (link_state_reg == LINK_SELECTED);

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rx_shared_drive_en <= 1'b0;
      o_rx_channel_selected <= 1'b0;
      o_rx_selected_channel <= '0;
    end else begin
      o_rx_shared_drive_en <= selected & ~link_en_n;
      o_rx_channel_selected <= selected;
      o_rx_selected_channel <= sel_chan_reg;
    end
  end

  assign o_multi_phy_enable = multi_phy;

endmodule

/* sim/rx_addr_checker.sv */
// concurrent checks on the receive address block ports
`timescale 1ns/1ns
module rx_addr_checker
  import rx_addr_pkg::*;
(
  input wire logic i_ref_clk, i_sys_rst, i_hsel, i_hwrite,
  input wire logic [HADDR_W-1:0] i_haddr,
  input wire logic [1:0] i_htrans, o_hresp,
  input wire logic [HDATA_W-1:0] i_hwdata, o_hrdata,
  input wire logic i_rx_cell_bus_clock, o_hreadyout,
  input wire logic [ADDR_W-1:0] i_rx_phy_address_in,
  input wire logic o_rx_cell_available, o_rx_cell_available_oe,
  input wire logic o_rx_shared_drive_en, o_rx_channel_selected,
  input wire logic [CH_W-1:0] o_rx_selected_channel,
  input wire logic o_multi_phy_enable
);
  logic [1:0] lk_q;
  logic [3:0] cnt;
  logic [ADDR_W-1:0] last_addr;
  logic ctrl_wr, rd_dp, wbit, mp_q, mp_qq;
  wire take = i_hsel && i_htrans[1] && o_hreadyout;
  wire ctrl_hit = i_haddr == {IDX_UPPER_ZERO, CTRL_IDX, WORD_LANE};
  wire lk_rise = lk_q == 2'h1;
  // settle window: a multi-PHY change may move the pin by itself
  wire mp_steady = o_multi_phy_enable == mp_qq;
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lk_q <= 2'h0;
      cnt <= 4'hF;
      last_addr <= RESERVED_ADDR;
      ctrl_wr <= 1'b0;
      rd_dp <= 1'b0;
      wbit <= 1'b0;
      mp_q <= 1'b1;
      mp_qq <= 1'b1;
    end else begin
      lk_q <= {lk_q[0], i_rx_cell_bus_clock};
      cnt <= lk_rise ? 4'h0 : (cnt == 4'hF ? cnt : cnt + 4'h1);
      last_addr <= lk_rise ? i_rx_phy_address_in : last_addr;
      ctrl_wr <= take && i_hwrite && ctrl_hit;
      rd_dp <= take && !i_hwrite;
      wbit <= i_hwdata[MPHY_BIT];
      mp_q <= o_multi_phy_enable;
      mp_qq <= mp_q;
    end
  end
  default clocking dc @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  a_bus_okay: assert property (o_hreadyout && o_hresp == HRESP_OKAY)
    else $error("bus answer not ready or not okay");
  a_rd_upper_zero: assert property (
    rd_dp |-> o_hrdata[HDATA_W-1:REG_W] == '0)
    else $error("read data upper bits not zero");
  a_mphy_bit: assert property (
    ctrl_wr |=> o_multi_phy_enable == wbit)
    else $error("multi-PHY enable does not follow control bit");
  a_drive_sel: assert property (
    o_rx_shared_drive_en |-> o_rx_channel_selected)
    else $error("shared drive without selection");
  a_clav_quiet: assert property (
    !o_rx_cell_available_oe |-> !o_rx_cell_available)
    else $error("cell available high while released");
  a_oe_on_link: assert property (
    $changed(o_rx_cell_available_oe) && mp_steady |-> cnt <= 4'h8)
    else $error("cell available enable moved without link edge");
  a_clav_hold: assert property (
    cnt > 4'h8 && o_multi_phy_enable && mp_steady
    |-> $stable(o_rx_cell_available))
    else $error("cell available moved between link edges");
  a_no_reserved: assert property (
    cnt == 4'h8 && last_addr == RESERVED_ADDR && o_multi_phy_enable
    |-> !o_rx_cell_available_oe)
    else $error("reserved address answered");
  a_sel_on_link: assert property (
    $changed(o_rx_selected_channel) || $rose(o_rx_channel_selected)
    |-> cnt <= 4'h8)
    else $error("selection moved without link edge");
  c_oe: cover property ($rose(o_rx_cell_available_oe));
  c_drive: cover property (o_rx_shared_drive_en);
  c_ctrl: cover property (ctrl_wr);
  c_single: cover property (!o_multi_phy_enable && o_rx_cell_available_oe);
endmodule

bind rx_channel_address_assign rx_addr_checker u_chk (
  .i_ref_clk, .i_sys_rst, .i_hsel, .i_hwrite, .i_haddr, .i_htrans,
  .o_hresp, .i_hwdata, .o_hrdata, .i_rx_cell_bus_clock, .o_hreadyout,
  .i_rx_phy_address_in, .o_rx_cell_available, .o_rx_cell_available_oe,
  .o_rx_shared_drive_en, .o_rx_channel_selected, .o_rx_selected_channel,
  .o_multi_phy_enable);

/* sim/rx_layer_proc_model.sv */
// layer processor model driving the receive polling pins
`timescale 1ns/1ns
module rx_layer_proc_model
  import rx_addr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_clav,
  input wire logic i_clav_oe,
  output logic o_link_clk,
  output logic o_en_n,
  output logic [ADDR_W-1:0] o_addr,
  output logic o_seen,
  output logic [1:0] o_seen_val
);
  initial begin
    o_link_clk = 1'b0;
    o_en_n = 1'b1;
    o_addr = RESERVED_ADDR;
    o_seen = 1'b0;
    o_seen_val = 2'h0;
  end
  // one link period per poll; the clock stands low between polls
  task automatic poll(input logic [ADDR_W-1:0] ad, input logic en_n);
    @(posedge i_ref_clk);
    o_addr <= ad;
    o_en_n <= en_n;
    #40 o_link_clk <= 1'b1;
    #40 o_link_clk <= 1'b0;
    #40;
    @(posedge i_ref_clk);
    o_seen_val <= {i_clav_oe, i_clav};
    o_seen <= 1'b1;
    @(posedge i_ref_clk);
    o_seen <= 1'b0;
    o_addr <= ~ad;
  endtask
endmodule

/* sim/rx_channel_address_assign_tb_top.sv */
// self-checking bench for the receive address assignment block
`timescale 1ns/1ns
`define CHK(e, g) begin check_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("unexpected at %0t exp %h got %h", \
  $time, e, g); end end
module rx_channel_address_assign_tb_top
  import rx_addr_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rd_dp = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [HADDR_W-1:0] haddr = '0;
  logic [HDATA_W-1:0] hwdata = '0;
  logic [N_CHAN-1:0] ready = '0;
  logic [HDATA_W-1:0] hrdata, ev;
  logic [1:0] hresp, seen_val;
  logic hrdyo, lk, en_n, clav, oe, seen, drv;
  logic [ADDR_W-1:0] paddr;
  logic [ADDR_W-1:0] a [N_CHAN];
  logic [HDATA_W-1:0] exp_q [$];
  int n_mismatch = 0;
  int check_count = 0;

  rx_channel_address_assign DUT (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hrdyo), .o_hrdata(hrdata),
    .o_hreadyout(hrdyo), .o_hresp(hresp), .i_rx_cell_bus_clock(lk),
    .i_rx_read_enable_n(en_n), .i_rx_phy_address_in(paddr),
    .i_rx_cell_ready(ready), .o_rx_cell_available(clav),
    .o_rx_cell_available_oe(oe), .o_rx_shared_drive_en(drv),
    .o_rx_channel_selected(), .o_rx_selected_channel(),
    .o_multi_phy_enable());

  rx_layer_proc_model u_lp (
    .i_ref_clk(clk), .i_clav(clav), .i_clav_oe(oe), .o_link_clk(lk),
    .o_en_n(en_n), .o_addr(paddr), .o_seen(seen), .o_seen_val(seen_val));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic bus(input logic wr, input logic [11:0] idx,
                     input logic [7:0] d, input logic [7:0] e);
    logic [23:0] junk;
    junk = 24'($urandom);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {IDX_UPPER_ZERO, idx, WORD_LANE};
    htrans <= HTRANS_NONSEQ_BIT;
    hwrite <= wr;
    do @(posedge clk); while (hrdyo !== 1'b1);
    if (!wr) exp_q.push_back({24'h00_0000, e});
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {junk, d};
    do @(posedge clk); while (hrdyo !== 1'b1);
  endtask

  task automatic poll(input logic [ADDR_W-1:0] ad, input logic en,
                      input logic [1:0] e, input logic dr = 1'b0);
    exp_q.push_back({29'h0000_0000, dr, e});
    u_lp.poll(ad, en);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // read data is taken at the edge that ends the data phase
  always @(posedge clk) begin
    rd_dp <= hsel && htrans[1] && !hwrite && hrdyo;
    if (rd_dp || seen) ev = exp_q.pop_front();
    if (rd_dp) `CHK(ev, hrdata)
    if (seen) `CHK(ev, {29'h0000_0000, drv, seen_val})
  end

  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(48762));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, CTRL_IDX, 8'h00, CTRL_RST);
    bus(1'b0, ADDR_PTR_IDX, 8'h00, {3'h0, PTR_RST});
    bus(1'b0, ADDR_VAL_IDX, 8'h00, {3'h0, ADDR_RST});
    bus(1'b1, 12'h0600, 8'hFF, 8'h00);
    bus(1'b0, 12'h0600, 8'h00, 8'h00);
    // distinct addresses below the reserved value
    for (int c = 0; c < N_CHAN; c++) begin
      a[c] = 5'(c * 8 + $urandom % 7);
      bus(1'b1, ADDR_PTR_IDX, {3'h7, 5'(c)}, 8'h00);
      bus(1'b1, ADDR_VAL_IDX, {3'h7, a[c]}, 8'h00);
    end
    for (int c = N_CHAN - 1; c >= 0; c--) begin
      bus(1'b1, ADDR_PTR_IDX, {3'h7, 5'(c)}, 8'h00);
      bus(1'b0, ADDR_PTR_IDX, 8'h00, 8'(c));
      bus(1'b0, ADDR_VAL_IDX, 8'h00, {3'h0, a[c]});
    end
    bus(1'b1, ADDR_PTR_IDX, {3'h0, PTR_LIMIT}, 8'h00);
    bus(1'b1, ADDR_VAL_IDX, 8'h05, 8'h00);
    bus(1'b0, ADDR_VAL_IDX, 8'h00, 8'h00);
    for (int r = 0; r < 2; r++) begin
      @(posedge clk) ready <= 4'($urandom);
      @(posedge clk);
      for (int c = 0; c < N_CHAN; c++)
        poll(a[c], 1'b0, {1'b1, ready[c]});
      poll(RESERVED_ADDR, 1'b0, 2'h0);
      poll(5'h07, 1'b0, 2'h0);
    end
    poll(a[1], 1'b1, {1'b1, ready[1]});
    poll(a[1], 1'b0, {1'b1, ready[1]}, 1'b1);
    bus(1'b0, STATUS_IDX, 8'h00,
        {1'b1, 2'h1, 1'b1, 2'h1, ready[1], 1'b1});
    poll(RESERVED_ADDR, 1'b1, 2'h0);
    bus(1'b1, CTRL_IDX, CTRL_RST & 8'hBF, 8'h00);
    bus(1'b0, CTRL_IDX, 8'h00, CTRL_RST & 8'hBF);
    poll(RESERVED_ADDR, 1'b0, {1'b1, |ready});
    bus(1'b1, CTRL_IDX, CTRL_RST, 8'h00);
    poll(a[2], 1'b0, {1'b1, ready[2]});
    // let the monitor take the last answer before the verdict
    repeat (2) @(posedge clk);
    tally_and_finish;
  end
endmodule
